/* include/low_power_wake_control_regs.svh */
`ifndef LOW_POWER_WAKE_CONTROL_REGS_SVH
`define LOW_POWER_WAKE_CONTROL_REGS_SVH
// Register byte offsets on the bus.
`define OFS_OPCODE   4'h0
`define OFS_CONFIG   4'h4
`define OFS_STATUS   4'h8
`define OFS_BUSLATCH 4'hc
// Opcodes executed by a write to the opcode register.
`define OP_CLOCK_GATE  8'h01
`define OP_STOP_OSC    8'h82
`define OP_FLOAT_PORTS 8'ha2
`define OP_FLOAT_ALL   8'hc2
`define OP_UNFLOAT     8'h32
`define OP_IRQ_DISABLE 8'h15
// Configuration register bit positions.
`define CFG_EXT_MODE 0
`define CFG_IRQ_EN   1
`define CFG_IN_ISR   2
`define CFG_RESET    3'h0
// Wake qualification: address latch strobes that must pass.
`define WAKE_ALE_COUNT 2'h2
// Restart addresses.
`define VEC_IRQ   12'h003
`define VEC_RESET 12'h000
// Bus transfer type and response.
`define HTRANS_NONSEQ 2'h2
`define HRESP_OKAY    1'b0
`endif

/* include/low_power_wake_control_pkg.sv */
package low_power_wake_control_pkg;
  // Power sequencer states, one-hot.
  typedef enum logic [4:0] {
    ST_RUN  = 5'b00001,
    ST_GATE = 5'b00010,
    ST_STOP = 5'b00100,
    ST_HWPD = 5'b01000,
    ST_QUAL = 5'b10000
  } pwr_state_t;
  // Software float mode.
  typedef enum logic [1:0] {
    FL_NONE  = 2'h0,
    FL_PORTS = 2'h1,
    FL_ALL   = 2'h2
  } float_mode_t;
endpackage : low_power_wake_control_pkg

/* core/low_power_wake_control.sv */
// Operation
// - Opcode 01H gates CPU clock, oscillator runs.
// - Opcode 82H stops oscillator until wake.
// - Opcode A2H floats ports per program mode.
// - Opcode C2H floats outputs per program mode.
// - Float plus clock opcode combine until wake.
// - Irq wake enabled: two strobes vector 3.
// - Sleep inside handler resumes next instruction.
// - Irq wake disabled: two strobes resume.
// - Reset pin wake: two strobes reset 0.
// - Stopped oscillator pulls step-hold down.
// - Power-down pin stops oscillator, floats pins.
// - Hardware power-down retains all CPU state.
// - Pin release with reset low resets.
// - Pin release, irq low enabled: vector 3.
// - Handler-time power-down resumes next instruction.
// - Pin release, irq disabled: resume next.
// - Pin release, all high: resume in place.
// - Bus port data latch separate from address.
// - Unfloat opcode, irq low, reset low unfloat.
//
// Local design decisions: register access over AHB-Lite and the register offsets.
`include "low_power_wake_control_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module low_power_wake_control (
  input  wire logic        clock,           // 25 MHz clock.
  input  wire logic        rstn,            // Async reset, low.
  input  wire logic        hsel,            // Slave select.
  input  wire logic [31:0] haddr,           // Byte address.
  input  wire logic [1:0]  htrans,          // Transfer type.
  input  wire logic        hwrite,          // Write when high.
  input  wire logic [2:0]  hsize,           // Transfer size.
  input  wire logic [31:0] hwdata,          // Write data.
  input  wire logic        hready,          // Bus ready.
  output logic      [31:0] hrdata,          // Read data.
  output logic             hreadyout,       // Slave ready.
  output logic             hresp,           // Always OKAY.
  input  wire logic        external_irq_n,  // Irq pin, low.
  input  wire logic        reset_pin_n,     // Reset pin, low.
  input  wire logic        powerdown_ctl_pin, // Low = power-down.
  input  wire logic        step_hold_n,     // Step-hold pin.
  input  wire logic        addr_latch_strobe, // CPU strobe pulse.
  input  wire logic        fetch_active,    // External fetch.
  input  wire logic [7:0]  fetch_addr,      // Fetch address.
  output logic             osc_run,         // Oscillator enable.
  output logic             cpu_clk_en,      // CPU clock enable.
  output logic             cpu_hold,        // CPU held.
  output logic             step_hold_pd,    // Step-hold pull-down.
  output logic             cpu_reset,       // Reset pulse.
  output logic             cpu_vector,      // Vector pulse.
  output logic             cpu_resume,      // Resume pulse.
  output logic      [11:0] vector_addr,     // Vector target.
  output logic             port_one_float,  // Port one off.
  output logic             port_two_lo_float, // Bits 0-3 off.
  output logic             port_two_hi_float, // Bits 4-7 off.
  output logic             bus_port_float,  // Bus port off.
  output logic             ale_float,       // Strobe pin off.
  output logic             fetch_float,     // Fetch strobe off.
  output logic             misc_out_float,  // Other outputs off.
  output logic      [7:0]  bus_port_out     // Bus port data.
);
  import low_power_wake_control_pkg::*;

  pwr_state_t  state_reg, state_next, from_reg;
  float_mode_t float_reg;
  logic [2:0]  cfg_reg;
  logic [7:0]  bus_latch_reg;
  logic [1:0]  cnt_reg;
  logic        src_rst_reg;
  logic        op_go;
  logic [7:0]  op_val;
  logic [3:0]  pin_meta, pin_sync;
  logic        irq_s, rst_s, pd_s, sh_s;
  logic        ap_wr, ap_rd;
  logic [3:0]  ap_ofs;
  logic        wake_src, osc_off;

  // Two flip-flop synchronisers for the irq, reset, power-down and step-hold pin inputs.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          pin_meta[gi] <= 1'b1;
          pin_sync[gi] <= 1'b1;
        end else begin
          pin_meta[gi] <= (gi == 0) ? external_irq_n :
                          (gi == 1) ? reset_pin_n :
                          (gi == 2) ? powerdown_ctl_pin :
                                      step_hold_n;
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate
  assign irq_s = pin_sync[0];
  assign rst_s = pin_sync[1];
  assign pd_s  = pin_sync[2];
  assign sh_s  = pin_sync[3];

  // Bus address phase capture; the slave never waits.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ap_wr  <= 1'b0;
      ap_rd  <= 1'b0;
      ap_ofs <= 4'h0;
    end else if (hready) begin
      ap_wr  <= hsel && htrans == `HTRANS_NONSEQ && hwrite;
      ap_rd  <= hsel && htrans == `HTRANS_NONSEQ && !hwrite;
      ap_ofs <= haddr[3:0];
    end
  end

  // An opcode write is one execution request.
  assign op_go  = ap_wr && ap_ofs == `OFS_OPCODE;
  assign op_val = hwdata[7:0];

  // Read data is prepared in the address phase.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= `HRESP_OKAY;
    end else if (hready && hsel && !hwrite &&
                 htrans == `HTRANS_NONSEQ) begin
      case (haddr[3:0])
        `OFS_CONFIG:   hrdata <= {29'h0, cfg_reg};
        `OFS_STATUS:   hrdata <= {19'h0, cnt_reg, float_reg,
                                  sh_s, pd_s, rst_s, irq_s,
                                  state_reg};
        `OFS_BUSLATCH: hrdata <= {24'h0, bus_latch_reg};
        default:       hrdata <= 32'h0;
      endcase
    end
  end

  // Configuration; the disable opcode clears the irq enable.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_reg <= `CFG_RESET;
    end else if (ap_wr && ap_ofs == `OFS_CONFIG) begin
      cfg_reg <= hwdata[2:0];
    end else if (op_go && op_val == `OP_IRQ_DISABLE) begin
      cfg_reg[`CFG_IRQ_EN] <= 1'b0;
    end
  end

  // Bus port data latch, apart from the fetch address.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bus_latch_reg <= 8'h0;
    end else if (ap_wr && ap_ofs == `OFS_BUSLATCH) begin
      bus_latch_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bus_port_out <= 8'h0;
    end else begin
      bus_port_out <= fetch_active ? fetch_addr
                                   : bus_latch_reg;
    end
  end

  // Float mode: set by opcodes, ended by opcode or pin lows.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      float_reg <= FL_NONE;
    end else if (state_reg != ST_HWPD && (!irq_s || !rst_s)) begin
      float_reg <= FL_NONE;
    end else if (op_go && state_reg == ST_RUN) begin
      if (op_val == `OP_FLOAT_PORTS) begin
        float_reg <= FL_PORTS;
      end else if (op_val == `OP_FLOAT_ALL) begin
        float_reg <= FL_ALL;
      end else if (op_val == `OP_UNFLOAT) begin
        float_reg <= FL_NONE;
      end
    end
  end

  // Wake source level: reset pin wins over irq pin.
  assign wake_src = src_rst_reg ? rst_s : irq_s;
  assign osc_off  = state_next == ST_STOP ||
                    state_next == ST_HWPD;

  // Sequencer next state.
  always_comb begin
    state_next = state_reg;
    if (!pd_s) begin
      state_next = ST_HWPD;
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (op_go && op_val == `OP_CLOCK_GATE) begin
            state_next = ST_GATE;
          end else if (op_go && op_val == `OP_STOP_OSC) begin
            state_next = ST_STOP;
          end
        end
        ST_GATE, ST_STOP: begin
          if (!rst_s || !irq_s) begin
            state_next = ST_QUAL;
          end
        end
        ST_HWPD: begin
          if (!rst_s || !irq_s) begin
            state_next = ST_QUAL;
          end else begin
            state_next = ST_RUN;
          end
        end
        ST_QUAL: begin
          if (wake_src) begin
            state_next = from_reg;
          end else if (cnt_reg == `WAKE_ALE_COUNT) begin
            state_next = ST_RUN;
          end
        end
        default: state_next = ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Remember where a wake began and which pin drives it.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      from_reg    <= ST_RUN;
      src_rst_reg <= 1'b0;
    end else if (state_reg != ST_QUAL &&
                 state_next == ST_QUAL) begin
      from_reg    <= (state_reg == ST_HWPD) ? ST_RUN : state_reg;
      src_rst_reg <= !rst_s;
    end
  end

  // Strobe counter on the restarted clock.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 2'h0;
    end else if (state_reg != ST_QUAL || wake_src) begin
      cnt_reg <= 2'h0;
    end else if (addr_latch_strobe &&
                 cnt_reg != `WAKE_ALE_COUNT) begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end

  // One-cycle restart pulses; an abandoned wake returns to gate or stop without a pulse, or resumes in place after power-down.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cpu_reset   <= 1'b0;
      cpu_vector  <= 1'b0;
      cpu_resume  <= 1'b0;
      vector_addr <= `VEC_RESET;
    end else begin
      cpu_reset  <= 1'b0;
      cpu_vector <= 1'b0;
      cpu_resume <= 1'b0;
      if (state_reg == ST_QUAL && state_next == ST_RUN &&
          !wake_src) begin
        if (src_rst_reg) begin
          cpu_reset   <= 1'b1;
          vector_addr <= `VEC_RESET;
        end else if (cfg_reg[`CFG_IRQ_EN] &&
                     !cfg_reg[`CFG_IN_ISR]) begin
          cpu_vector  <= 1'b1;
          vector_addr <= `VEC_IRQ;
        end else begin
          cpu_resume  <= 1'b1;
        end
      end else if (state_reg != ST_RUN &&
                   state_next == ST_RUN) begin
        cpu_resume <= 1'b1;
      end
    end
  end

  // Clock controls and the step-hold resistor switch.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      osc_run      <= 1'b1;
      cpu_clk_en   <= 1'b1;
      step_hold_pd <= 1'b0;
      cpu_hold     <= 1'b0;
    end else begin
      osc_run      <= !osc_off;
      cpu_clk_en   <= state_next == ST_RUN ||
                      state_next == ST_QUAL;
      step_hold_pd <= osc_off;
      if (osc_off) begin
        cpu_hold <= 1'b1;
      end else if (sh_s) begin
        cpu_hold <= 1'b0;
      end
    end
  end

  // Pin float enables from float mode, program mode and pin.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      port_one_float    <= 1'b0;
      port_two_lo_float <= 1'b0;
      port_two_hi_float <= 1'b0;
      bus_port_float    <= 1'b0;
      ale_float         <= 1'b0;
      fetch_float       <= 1'b0;
      misc_out_float    <= 1'b0;
    end else if (state_next == ST_HWPD) begin
      port_one_float    <= 1'b1;
      port_two_lo_float <= 1'b1;
      port_two_hi_float <= 1'b1;
      bus_port_float    <= 1'b1;
      ale_float         <= 1'b1;
      fetch_float       <= 1'b1;
      misc_out_float    <= 1'b1;
    end else begin
      port_one_float    <= float_reg != FL_NONE;
      port_two_hi_float <= float_reg != FL_NONE;
      port_two_lo_float <= float_reg != FL_NONE &&
                           !cfg_reg[`CFG_EXT_MODE];
      bus_port_float    <= float_reg != FL_NONE &&
                           !cfg_reg[`CFG_EXT_MODE];
      ale_float         <= float_reg == FL_ALL &&
                           !cfg_reg[`CFG_EXT_MODE];
      fetch_float       <= float_reg == FL_ALL &&
                           !cfg_reg[`CFG_EXT_MODE];
      misc_out_float    <= float_reg == FL_ALL;
    end
  end

  // Checks next to the logic above.
  a_gate_op_enter: assert property (@(posedge clock)
    disable iff (!rstn)
    state_reg == ST_RUN && pd_s && op_go &&
    op_val == `OP_CLOCK_GATE |=> state_reg == ST_GATE &&
    osc_run && !cpu_clk_en)
    else $error("clock gate opcode did not gate");
  a_stop_osc_off: assert property (@(posedge clock)
    disable iff (!rstn)
    state_reg == ST_STOP |-> !osc_run && !cpu_clk_en)
    else $error("oscillator runs in stop state");
  a_float_ports_int: assert property (@(posedge clock)
    disable iff (!rstn)
    $past(float_reg) == FL_PORTS && !$past(cfg_reg[`CFG_EXT_MODE]) &&
    state_reg != ST_HWPD |-> port_one_float &&
    port_two_lo_float && bus_port_float && !ale_float)
    else $error("ports not floated");
  a_float_all_ext: assert property (@(posedge clock)
    disable iff (!rstn)
    $past(float_reg) == FL_ALL && $past(cfg_reg[`CFG_EXT_MODE]) &&
    state_reg != ST_HWPD |-> !ale_float && !fetch_float &&
    !bus_port_float && misc_out_float && port_one_float)
    else $error("external mode float wrong");
  a_irq_vector: assert property (@(posedge clock)
    disable iff (!rstn)
    cpu_vector |-> $past(cnt_reg) == `WAKE_ALE_COUNT &&
    !$past(irq_s) && $past(cfg_reg[`CFG_IRQ_EN]) &&
    !$past(cfg_reg[`CFG_IN_ISR]) && vector_addr == `VEC_IRQ)
    else $error("vector without qualified irq");
  a_reset_wake: assert property (@(posedge clock)
    disable iff (!rstn)
    cpu_reset |-> $past(src_rst_reg) && !$past(rst_s) &&
    vector_addr == `VEC_RESET && cpu_clk_en)
    else $error("reset wake not qualified");
  a_hwpd_float: assert property (@(posedge clock)
    disable iff (!rstn)
    !pd_s |=> state_reg == ST_HWPD && !osc_run &&
    port_one_float && bus_port_float && ale_float)
    else $error("pin power-down not applied");
  a_hwpd_resume: assert property (@(posedge clock)
    disable iff (!rstn)
    state_reg == ST_HWPD && pd_s && rst_s && irq_s
    |=> state_reg == ST_RUN && cpu_resume && osc_run)
    else $error("pin release did not resume");
  a_step_pull: assert property (@(posedge clock)
    disable iff (!rstn)
    $rose(step_hold_pd) |-> cpu_hold && !osc_run &&
    !cpu_clk_en)
    else $error("hold not set on pull-down");
  a_count_clear: assert property (@(posedge clock)
    disable iff (!rstn)
    state_reg == ST_QUAL && wake_src |=> cnt_reg == 2'h0)
    else $error("strobe count kept");
endmodule : low_power_wake_control
`default_nettype wire

/* tb/wake_board_model.sv */
`timescale 1ns/1ps
`default_nettype none
module wake_board_model #(
  parameter int STABLE   = 6, // Cycles the oscillator needs to settle.
  parameter int SH_DELAY = 4  // Cycles the step-hold capacitor charges.
) (
  input  wire logic clock,             // System clock.
  input  wire logic rstn,              // Reset, active low.
  input  wire logic irq_cmd,           // Bench pulls the irq pin low.
  input  wire logic rst_cmd,           // Bench pulls the reset pin low.
  input  wire logic pd_cmd,            // Bench pulls power-down low.
  input  wire logic osc_run,           // Oscillator enable seen.
  input  wire logic cpu_clk_en,        // CPU clock enable seen.
  input  wire logic cpu_hold,          // CPU hold seen.
  input  wire logic step_hold_pd,      // Step-hold pull-down seen.
  output logic      external_irq_n,    // Irq pin.
  output logic      reset_pin_n,       // Reset pin.
  output logic      powerdown_ctl_pin, // Power-down pin.
  output logic      step_hold_n,       // Step-hold pin.
  output logic      addr_latch_strobe  // Strobe from the CPU.
);
  logic [3:0] settle_cnt;
  logic [3:0] charge_cnt;
  logic [1:0] div_cnt;
  // The plain wake pins follow the bench commands.
  assign external_irq_n = !irq_cmd;
  assign powerdown_ctl_pin = !pd_cmd;
  // Reset is stretched until a restarted oscillator has settled.
  assign reset_pin_n = !(rst_cmd || settle_cnt != 4'h0);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) settle_cnt <= 4'h0;
    else if (rst_cmd && !osc_run) settle_cnt <= STABLE[3:0];
    else if (osc_run && settle_cnt != 4'h0) settle_cnt <= settle_cnt - 4'h1;
  end
  // The CPU strobes every fourth cycle while it is clocked and free.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) div_cnt <= 2'h0;
    else if (osc_run && cpu_clk_en && !cpu_hold) div_cnt <= div_cnt + 2'h1;
  end
  assign addr_latch_strobe = div_cnt == 2'h3 && osc_run && cpu_clk_en
                             && !cpu_hold;
  // The capacitor discharges under the pull-down and recharges slowly.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) charge_cnt <= SH_DELAY[3:0];
    else if (step_hold_pd) charge_cnt <= 4'h0;
    else if (charge_cnt != SH_DELAY[3:0]) charge_cnt <= charge_cnt + 4'h1;
  end
  assign step_hold_n = charge_cnt == SH_DELAY[3:0];
endmodule : wake_board_model
`default_nettype wire

/* tb/low_power_wake_control_test.sv */
`include "low_power_wake_control_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module low_power_wake_control_test;
  import low_power_wake_control_pkg::*;
  // One sleep case: config, float op, clock op, sources, restart, floats.
  typedef struct packed {
    logic [2:0] cfg;
    logic [7:0] fl;
    logic [7:0] op;
    logic       hw;
    logic       irq;
    logic       rst;
    logic [1:0] kind;
    logic [6:0] fexp;
  } row_t;
  localparam int SH_DELAY = 4;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        irq_cmd = 1'b0;
  logic        rst_cmd = 1'b0;
  logic        pd_cmd = 1'b0;
  logic        fetch_active = 1'b0;
  logic [7:0]  fetch_addr = 8'h0;
  logic        external_irq_n, reset_pin_n, powerdown_ctl_pin;
  logic        step_hold_n, addr_latch_strobe, osc_run, cpu_clk_en;
  logic        cpu_hold, step_hold_pd, cpu_reset, cpu_vector, cpu_resume;
  logic [11:0] vector_addr;
  logic [6:0]  floats;
  logic [7:0]  bus_port_out;
  logic [1:0]  last_kind = 2'h3;
  logic [3:0]  asleep;
  logic [31:0] rd;
  int          n_pulse = 0;
  int          n_before = 0;
  int          n_errors = 0;
  int          compares = 0;
  row_t        rows [10] = '{
    '{3'h2, 8'h00, 8'h01, 1'b0, 1'b1, 1'b0, 2'h1, 7'h00},
    '{3'h6, 8'h00, 8'h01, 1'b0, 1'b1, 1'b0, 2'h2, 7'h00},
    '{3'h0, 8'ha2, 8'h82, 1'b0, 1'b1, 1'b0, 2'h2, 7'h78},
    '{3'h1, 8'hc2, 8'h82, 1'b0, 1'b0, 1'b1, 2'h0, 7'h51},
    '{3'h0, 8'hc2, 8'h01, 1'b0, 1'b1, 1'b0, 2'h2, 7'h7f},
    '{3'h1, 8'ha2, 8'h01, 1'b0, 1'b1, 1'b0, 2'h2, 7'h50},
    '{3'h2, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0, 2'h2, 7'h7f},
    '{3'h2, 8'h00, 8'h00, 1'b1, 1'b1, 1'b0, 2'h1, 7'h7f},
    '{3'h6, 8'h00, 8'h00, 1'b1, 1'b1, 1'b0, 2'h2, 7'h7f},
    '{3'h0, 8'h00, 8'h00, 1'b1, 1'b0, 1'b1, 2'h0, 7'h7f}};
  // The clock toggles every half period of 20 ns.
  always #20 clock = ~clock;
  low_power_wake_control u_low_power_wake_control (
    .clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .external_irq_n(external_irq_n),
    .reset_pin_n(reset_pin_n), .powerdown_ctl_pin(powerdown_ctl_pin),
    .step_hold_n(step_hold_n), .addr_latch_strobe(addr_latch_strobe),
    .fetch_active(fetch_active), .fetch_addr(fetch_addr),
    .osc_run(osc_run), .cpu_clk_en(cpu_clk_en), .cpu_hold(cpu_hold),
    .step_hold_pd(step_hold_pd), .cpu_reset(cpu_reset),
    .cpu_vector(cpu_vector), .cpu_resume(cpu_resume),
    .vector_addr(vector_addr), .port_one_float(floats[6]),
    .port_two_lo_float(floats[5]), .port_two_hi_float(floats[4]),
    .bus_port_float(floats[3]), .ale_float(floats[2]),
    .fetch_float(floats[1]), .misc_out_float(floats[0]),
    .bus_port_out(bus_port_out));
  wake_board_model #(.SH_DELAY(SH_DELAY)) u_wake_board_model (
    .clock(clock), .rstn(rstn), .irq_cmd(irq_cmd), .rst_cmd(rst_cmd),
    .pd_cmd(pd_cmd), .osc_run(osc_run), .cpu_clk_en(cpu_clk_en),
    .cpu_hold(cpu_hold), .step_hold_pd(step_hold_pd),
    .external_irq_n(external_irq_n), .reset_pin_n(reset_pin_n),
    .powerdown_ctl_pin(powerdown_ctl_pin), .step_hold_n(step_hold_n),
    .addr_latch_strobe(addr_latch_strobe));
  // Records which restart the sequencer last asked of the CPU.
  always @(posedge clock) begin
    if (cpu_reset === 1'b1) last_kind <= 2'h0;
    if (cpu_vector === 1'b1) last_kind <= 2'h1;
    if (cpu_resume === 1'b1) last_kind <= 2'h2;
    if ((cpu_reset | cpu_vector | cpu_resume) === 1'b1) n_pulse <= n_pulse + 1;
  end
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask : check
  // One single word transfer; read data is taken at the data phase edge.
  task automatic bus_cycle(input logic [31:0] a, input logic wr,
                           input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= `HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus_cycle
  task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
    bus_cycle(a, 1'b1, d);
  endtask : bus_write
  task automatic read_check(input string what, input logic [31:0] a,
                            input logic [31:0] exp);
    bus_cycle(a, 1'b0, 32'h0);
    check(what, exp, rd);
  endtask : read_check
  task automatic pins(input logic irq, input logic rst, input logic pd);
    @(posedge clock);
    irq_cmd <= irq;
    rst_cmd <= rst;
    pd_cmd <= pd;
  endtask : pins
  // Waits, bounded, for one restart pulse.
  task automatic wait_pulse();
    int first;
    first = n_pulse;
    for (int i = 0; i < 200 && n_pulse == first; i++) @(negedge clock);
    check("restart pulses", first + 1, n_pulse);
  endtask : wait_pulse
  task automatic conclude();
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    conclude();
  end
  // Main sequence of register and wake tests.
  initial begin
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    read_check("config", `OFS_CONFIG, 32'h0);
    read_check("status", `OFS_STATUS, 32'h1e1);
    read_check("opcode", `OFS_OPCODE, 32'h0);
    read_check("unmapped", 32'h10, 32'h0);
    check("response", {31'h0, `HRESP_OKAY}, {31'h0, hresp});
    bus_write(`OFS_CONFIG, 32'h2);
    bus_write(`OFS_OPCODE, {24'h0, `OP_IRQ_DISABLE});
    read_check("irq enable", `OFS_CONFIG, 32'h0);
    bus_write(`OFS_OPCODE, {24'h0, `OP_FLOAT_PORTS});
    repeat (2) @(negedge clock);
    check("float", 32'h78, {25'h0, floats});
    bus_write(`OFS_OPCODE, {24'h0, `OP_UNFLOAT});
    repeat (2) @(negedge clock);
    check("unfloat", 32'h0, {25'h0, floats});
    // The data latch must survive an external fetch on the bus port.
    @(posedge clock);
    fetch_addr <= 8'h3c;
    fetch_active <= 1'b1;
    bus_write(`OFS_BUSLATCH, 32'h5a);
    repeat (2) @(negedge clock);
    check("fetch address", 32'h3c, {24'h0, bus_port_out});
    @(posedge clock);
    fetch_active <= 1'b0;
    repeat (2) @(negedge clock);
    check("bus latch", 32'h5a, {24'h0, bus_port_out});
    read_check("bus latch reg", `OFS_BUSLATCH, 32'h5a);
    // A short irq low must not wake the gated CPU.
    bus_write(`OFS_CONFIG, 32'h0);
    bus_write(`OFS_OPCODE, {24'h0, `OP_CLOCK_GATE});
    n_before = n_pulse;
    // Six low cycles give the woken CPU room for exactly one strobe.
    pins(1'b1, 1'b0, 1'b0);
    repeat (5) @(posedge clock);
    pins(1'b0, 1'b0, 1'b0);
    repeat (6) @(posedge clock);
    read_check("aborted", `OFS_STATUS, {23'h0, 4'hf, ST_GATE});
    check("no restart", n_before, n_pulse);
    pins(1'b1, 1'b0, 1'b0);
    wait_pulse();
    check("resume kind", 32'h2, {30'h0, last_kind});
    pins(1'b0, 1'b0, 1'b0);
    // Gate, stop and power-down with irq wakes, reset wakes from stop and power-down, and a plain pin release.
    foreach (rows[i]) begin
      bus_write(`OFS_CONFIG, {29'h0, rows[i].cfg});
      if (rows[i].fl != 8'h0) bus_write(`OFS_OPCODE, {24'h0, rows[i].fl});
      if (rows[i].hw) pins(1'b0, 1'b0, 1'b1);
      else bus_write(`OFS_OPCODE, {24'h0, rows[i].op});
      repeat (5) @(negedge clock);
      asleep = rows[i].hw || rows[i].op == `OP_STOP_OSC ? 4'h3 : 4'h8;
      check("floats", rows[i].fexp, floats);
      check("sleep", asleep, {osc_run, cpu_clk_en, step_hold_pd,
                              cpu_hold});
      pins(rows[i].irq, rows[i].rst, 1'b0);
      wait_pulse();
      check("kind", rows[i].kind, last_kind);
      if (rows[i].kind != 2'h2)
        check("address", rows[i].kind == 2'h1 ? `VEC_IRQ : `VEC_RESET,
              vector_addr);
      pins(1'b0, 1'b0, 1'b0);
      repeat (SH_DELAY + 8) @(negedge clock);
      check("awake", 32'h600, {osc_run, cpu_clk_en, floats, step_hold_pd,
                               cpu_hold});
    end
    conclude();
  end
endmodule : low_power_wake_control_test
`default_nettype wire
